// file: hw/rsc_pkg.sv
/*
 * Shared types and constants for the role and session controller.
 * Assumes a single clock domain and synchronous request strobes.
 */
package rsc_pkg;

    localparam int ACCT_MAX_DEF = 128;

    // management slot content
    typedef enum logic [2:0] {
        MGMT_NONE,
        MGMT_INITIATOR,
        MGMT_OFFICER,
        MGMT_MANAGER,
        MGMT_USER
    } rsc_mgmt_t;

    // datapath slot content
    typedef enum logic [1:0] {
        DP_NONE,
        DP_SECURE,
        DP_MIGRATE,
        DP_PREBOOT
    } rsc_dp_t;

    // account type presented with a login
    typedef enum logic [2:0] {
        ACCT_INITIATOR,
        ACCT_OFFICER,
        ACCT_INIT_OFFICER,
        ACCT_MANAGER,
        ACCT_USER
    } rsc_acct_t;

    // datapath grant service
    typedef enum logic [1:0] {
        SVC_BOOT,
        SVC_MIGRATE_KEY,
        SVC_UNLOCK_PREBOOT
    } rsc_svc_t;

    // key selection for the cipher path
    localparam logic KEY_OLD = 1'b0;
    localparam logic KEY_NEW = 1'b1;

endpackage : rsc_pkg

// file: hw/rsc_login_check.sv
/*
 * Login admission: decides whether a requested management role may be
 * taken given account type, account population and slot occupancy.
 * Assumes authentication has already been judged outside this block.
 */
`timescale 1ns/1ps
module rsc_login_check
    import rsc_pkg::*;
(
    input  wire rsc_acct_t acct_type_i,
    input  wire rsc_mgmt_t role_req_i,
    input  wire logic      accounts_exist_i,
    input  wire rsc_mgmt_t mgmt_i,
    input  wire logic      purged_i,
    output logic           ok_o
);
    logic type_ok;

    always_comb begin
        type_ok = 1'b0;
        case (acct_type_i)
            ACCT_INITIATOR: begin
                type_ok = (role_req_i == MGMT_INITIATOR)
                          && !accounts_exist_i;
            end
            ACCT_OFFICER, ACCT_INIT_OFFICER: begin
                type_ok = (role_req_i == MGMT_OFFICER)
                       || (role_req_i == MGMT_MANAGER)
                       || (role_req_i == MGMT_USER);
            end
            ACCT_MANAGER: begin
                type_ok = (role_req_i == MGMT_MANAGER)
                       || (role_req_i == MGMT_USER);
            end
            ACCT_USER: begin
                type_ok = (role_req_i == MGMT_USER);
            end
            default: begin
                type_ok = 1'b0;
            end
        endcase
        if (acct_type_i != ACCT_INITIATOR && !accounts_exist_i) begin
            type_ok = 1'b0;
        end
        // slot must be empty: no role switch without logout
        ok_o = type_ok && (mgmt_i == MGMT_NONE)
               && !purged_i;
    end

endmodule : rsc_login_check

// file: hw/rsc_grant_check.sv
/*
 * Datapath grant admission: checks a service request for a datapath
 * role against the current management role and datapath slot.
 * Assumes the service code is valid only with its strobe.
 */
`timescale 1ns/1ps
module rsc_grant_check
    import rsc_pkg::*;
(
    input  wire rsc_svc_t  svc_i,
    input  wire rsc_mgmt_t mgmt_i,
    input  wire rsc_dp_t   dp_i,
    input  wire logic      purged_i,
    output rsc_dp_t        role_o,
    output logic           ok_o
);
    always_comb begin
        role_o = DP_NONE;
        ok_o   = 1'b0;
        case (svc_i)
            SVC_BOOT: begin
                role_o = DP_SECURE;
                ok_o   = (mgmt_i == MGMT_OFFICER)
                      || (mgmt_i == MGMT_MANAGER)
                      || (mgmt_i == MGMT_USER);
            end
            SVC_MIGRATE_KEY: begin
                role_o = DP_MIGRATE;
                ok_o   = (mgmt_i == MGMT_OFFICER);
            end
            SVC_UNLOCK_PREBOOT: begin
                role_o = DP_PREBOOT;
                ok_o   = (mgmt_i == MGMT_OFFICER);
            end
            default: begin
                role_o = DP_NONE;
                ok_o   = 1'b0;
            end
        endcase
        // a held datapath role must be released first
        if (dp_i != DP_NONE || purged_i) begin
            ok_o = 1'b0;
        end
    end

endmodule : rsc_grant_check

// file: hw/rsc_role_session.sv
/*
 * Role and session controller: management and datapath role slots,
 * login and grant admission, logout and error clearing, and the
 * region and key gating for host reads and writes.
 * Assumes requests are one-cycle strobes synchronous to clk_sys_i and
 * that authentication of a login is judged before the strobe.
 */
`timescale 1ns/1ps
module rsc_role_session
    import rsc_pkg::*;
#(
    parameter int ACCT_MAX = ACCT_MAX_DEF
) (
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    input  wire logic      restart_i,
    input  wire logic      error_i,
    input  wire logic      purge_i,
    input  wire logic      login_i,
    input  wire rsc_acct_t login_acct_i,
    input  wire rsc_mgmt_t login_role_i,
    input  wire logic      mgmt_logout_i,
    input  wire logic      grant_i,
    input  wire rsc_svc_t  grant_svc_i,
    input  wire logic      grant_keep_i,
    input  wire logic      dp_logout_i,
    input  wire logic      acct_create_i,
    input  wire rsc_acct_t acct_create_type_i,
    input  wire logic      acct_delete_i,
    input  wire logic      preboot_ro_en_i,
    input  wire logic      host_rd_i,
    input  wire logic      host_wr_i,
    input  wire logic      host_preboot_i,
    output rsc_mgmt_t      mgmt_role_o,
    output rsc_dp_t        dp_role_o,
    output logic           login_ack_o,
    output logic           login_nak_o,
    output logic           grant_ack_o,
    output logic           grant_nak_o,
    output logic [7:0]     acct_count_o,
    output logic           purged_o,
    output logic           access_ok_o,
    output logic           cipher_en_o,
    output logic           key_sel_o
);
    localparam int CW = $clog2(ACCT_MAX + 1);

    // account count port is 8 bits wide
    if (ACCT_MAX < 1 || CW > 8) begin : g_bad_acct_max
        $error("ACCT_MAX out of range");
    end

    rsc_mgmt_t    mgmt, next_mgmt;
    rsc_dp_t      dp, next_dp;
    logic [CW-1:0] acct_cnt, next_acct_cnt;
    logic         init_off, next_init_off;
    logic         purged, next_purged;
    logic         next_login_ack, next_login_nak;
    logic         next_grant_ack, next_grant_nak;
    logic         next_access_ok, next_cipher_en, next_key_sel;
    logic         login_ok, grant_ok, accounts_exist, clear_all;
    rsc_dp_t      grant_role;

    assign accounts_exist = (acct_cnt != '0);
    assign clear_all      = restart_i;

    rsc_login_check u_login (
        .acct_type_i      (login_acct_i),
        .role_req_i       (login_role_i),
        .accounts_exist_i (accounts_exist),
        .mgmt_i           (mgmt),
        .purged_i         (purged),
        .ok_o             (login_ok)
    );

    rsc_grant_check u_grant (
        .svc_i    (grant_svc_i),
        .mgmt_i   (mgmt),
        .dp_i     (dp),
        .purged_i (purged),
        .role_o   (grant_role),
        .ok_o     (grant_ok)
    );

    // slot state: one of login, grant or management logout per cycle; datapath logout alongside
    always_comb begin
        next_mgmt      = mgmt;
        next_dp        = dp;
        next_login_ack = 1'b0;
        next_login_nak = 1'b0;
        next_grant_ack = 1'b0;
        next_grant_nak = 1'b0;
        if (clear_all || error_i || purge_i) begin
            next_mgmt = MGMT_NONE;
            next_dp   = DP_NONE;
            next_login_nak = login_i;
            next_grant_nak = grant_i;
        end else begin
            if (login_i) begin
                if (login_ok) begin
                    next_mgmt      = login_role_i;
                    next_login_ack = 1'b1;
                end else begin
                    next_login_nak = 1'b1;
                end
            end else if (grant_i) begin
                if (grant_ok) begin
                    next_dp        = grant_role;
                    next_grant_ack = 1'b1;
                    // only boot may drop the management side
                    if (grant_svc_i == SVC_BOOT && !grant_keep_i) begin
                        next_mgmt = MGMT_NONE;
                    end
                end else begin
                    next_grant_nak = 1'b1;
                end
            end else if (mgmt_logout_i) begin
                next_mgmt = MGMT_NONE;
            end
            if (dp_logout_i && !(grant_i && grant_ok)) begin
                next_dp = DP_NONE;
            end
        end
    end

    // account population and purge latch
    always_comb begin
        next_acct_cnt = acct_cnt;
        next_init_off = init_off;
        next_purged   = purged;
        if (purge_i) begin
            next_purged   = 1'b1;
            next_acct_cnt = '0;
            next_init_off = 1'b0;
        end else if (acct_create_i && !purged) begin
            if (mgmt == MGMT_INITIATOR) begin
                // initiator may only make the single initial officer
                if (acct_create_type_i == ACCT_INIT_OFFICER && !init_off
                    && acct_cnt == '0) begin
                    next_init_off = 1'b1;
                    next_acct_cnt = acct_cnt + CW'(1);
                end
            end else if (mgmt == MGMT_OFFICER
                         && acct_create_type_i != ACCT_INITIATOR
                         && acct_create_type_i != ACCT_INIT_OFFICER
                         && acct_cnt < CW'(ACCT_MAX)) begin
                next_acct_cnt = acct_cnt + CW'(1);
            end
        end else if (acct_delete_i && mgmt == MGMT_OFFICER
                     && acct_cnt != '0) begin
            next_acct_cnt = acct_cnt - CW'(1);
        end
    end

    // host access gating by datapath role
    always_comb begin
        next_access_ok = 1'b0;
        next_cipher_en = 1'b0;
        next_key_sel   = KEY_NEW;
        case (dp)
            DP_SECURE: begin
                next_access_ok = (host_rd_i || host_wr_i)
                                 && !host_preboot_i;
                next_cipher_en = next_access_ok;
            end
            DP_MIGRATE: begin
                next_access_ok = (host_rd_i || host_wr_i)
                                 && !host_preboot_i;
                next_cipher_en = next_access_ok;
                next_key_sel   = host_rd_i ? KEY_OLD : KEY_NEW;
            end
            DP_PREBOOT: begin
                next_access_ok = (host_rd_i || host_wr_i)
                                 && host_preboot_i;
                next_cipher_en = next_access_ok;
            end
            default: begin
                // plain read-only view; no key held
                next_access_ok = preboot_ro_en_i && host_rd_i
                                 && !host_wr_i && host_preboot_i;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mgmt        <= MGMT_NONE;
            dp          <= DP_NONE;
            acct_cnt    <= '0;
            init_off    <= 1'b0;
            purged      <= 1'b0;
            login_ack_o <= 1'b0;
            login_nak_o <= 1'b0;
            grant_ack_o <= 1'b0;
            grant_nak_o <= 1'b0;
            access_ok_o <= 1'b0;
            cipher_en_o <= 1'b0;
            key_sel_o   <= KEY_NEW;
        end else begin
            mgmt        <= next_mgmt;
            dp          <= next_dp;
            acct_cnt    <= next_acct_cnt;
            init_off    <= next_init_off;
            purged      <= next_purged;
            login_ack_o <= next_login_ack;
            login_nak_o <= next_login_nak;
            grant_ack_o <= next_grant_ack;
            grant_nak_o <= next_grant_nak;
            access_ok_o <= next_access_ok;
            cipher_en_o <= next_cipher_en;
            key_sel_o   <= next_key_sel;
        end
    end

    assign mgmt_role_o  = mgmt;
    assign dp_role_o    = dp;
    assign acct_count_o = 8'(acct_cnt);
    assign purged_o     = purged;

    property p_init_no_dp;
        @(posedge clk_sys_i) disable iff (rst_i)
        (grant_i && mgmt == MGMT_INITIATOR) |=> (grant_nak_o && dp == $past(dp));
    endproperty
    a_init_no_dp: assert property (p_init_no_dp)
        else $error("initiator obtained datapath role");

    property p_migrate_officer;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dp != DP_MIGRATE && dp != DP_PREBOOT ##1
         (dp == DP_MIGRATE || dp == DP_PREBOOT))
        |-> $past(mgmt) == MGMT_OFFICER;
    endproperty
    a_migrate_officer: assert property (p_migrate_officer)
        else $error("migrate or preboot role without officer");

    property p_no_dp_switch;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dp != DP_NONE) |=> (dp == $past(dp) || dp == DP_NONE);
    endproperty
    a_no_dp_switch: assert property (p_no_dp_switch)
        else $error("datapath role changed without release");

    property p_full_refuse;
        @(posedge clk_sys_i) disable iff (rst_i)
        (login_i && mgmt != MGMT_NONE) |=> (login_nak_o && !login_ack_o);
    endproperty
    a_full_refuse: assert property (p_full_refuse)
        else $error("login accepted into occupied slot");

    sequence s_error_seen;
        error_i;
    endsequence
    sequence s_slots_empty;
        (mgmt == MGMT_NONE && dp == DP_NONE);
    endsequence
    property p_error_clear;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_error_seen |=> s_slots_empty;
    endproperty
    a_error_clear: assert property (p_error_clear)
        else $error("error did not clear both slots");

    property p_dp_logout;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dp_logout_i && !grant_i) |=> dp == DP_NONE;
    endproperty
    a_dp_logout: assert property (p_dp_logout)
        else $error("datapath logout ignored");

    property p_secure_normal;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dp == DP_SECURE && host_preboot_i) |=> !access_ok_o;
    endproperty
    a_secure_normal: assert property (p_secure_normal)
        else $error("secure access reached preboot region");

    property p_migrate_key;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dp == DP_MIGRATE && host_rd_i && !host_preboot_i)
        |=> (access_ok_o && key_sel_o == KEY_OLD);
    endproperty
    a_migrate_key: assert property (p_migrate_key)
        else $error("migrate read not on old key");

    property p_purge_refuse;
        @(posedge clk_sys_i) disable iff (rst_i)
        (purged && login_i) |=> (login_nak_o && mgmt == MGMT_NONE);
    endproperty
    a_purge_refuse: assert property (p_purge_refuse)
        else $error("login accepted after purge");

endmodule : rsc_role_session

// file: tb/rsc_host_model.sv
/*
 * Host model for the role and session controller: issues login, grant,
 * logout, account and event strobes and host disk accesses.
 * Assumes the bench owns the clock; requests go out at rising edges.
 */
`timescale 1ns/1ps
module rsc_host_model
    import rsc_pkg::*;
(
    input  wire logic clk_sys_i,
    output logic      restart_o,
    output logic      error_o,
    output logic      purge_o,
    output logic      login_o,
    output rsc_acct_t login_acct_o,
    output rsc_mgmt_t login_role_o,
    output logic      mgmt_logout_o,
    output logic      grant_o,
    output rsc_svc_t  grant_svc_o,
    output logic      grant_keep_o,
    output logic      dp_logout_o,
    output logic      acct_create_o,
    output rsc_acct_t acct_create_type_o,
    output logic      acct_delete_o,
    output logic      host_rd_o,
    output logic      host_wr_o,
    output logic      host_preboot_o
);
    initial begin
        {restart_o, error_o, purge_o, login_o, mgmt_logout_o, grant_o,
         dp_logout_o, acct_create_o, acct_delete_o, host_rd_o,
         host_wr_o} = 11'h000;
        {grant_keep_o, host_preboot_o} = 2'h0;
        login_acct_o       = ACCT_USER;
        acct_create_type_o = ACCT_USER;
        login_role_o       = MGMT_NONE;
        grant_svc_o        = SVC_BOOT;
    end

    // one request held for exactly one sampling edge, then released
    task automatic pulse(input int unsigned sel, input rsc_acct_t a,
                         input rsc_mgmt_t r, input rsc_svc_t s,
                         input logic k, input logic pre);
        @(posedge clk_sys_i);
        login_acct_o       <= a;
        acct_create_type_o <= a;
        login_role_o       <= r;
        grant_svc_o        <= s;
        grant_keep_o       <= k;
        host_preboot_o     <= pre;
        case (sel)
            0: restart_o <= 1'b1;
            1: error_o <= 1'b1;
            2: purge_o <= 1'b1;
            3: login_o <= 1'b1;
            4: mgmt_logout_o <= 1'b1;
            5: grant_o <= 1'b1;
            6: dp_logout_o <= 1'b1;
            7: acct_create_o <= 1'b1;
            8: acct_delete_o <= 1'b1;
            9: host_rd_o <= 1'b1;
            default: host_wr_o <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        {restart_o, error_o, purge_o, login_o, mgmt_logout_o, grant_o,
         dp_logout_o, acct_create_o, acct_delete_o, host_rd_o,
         host_wr_o} <= 11'h000;
        // stale qualifiers must not look like the request just made
        login_acct_o       <= rsc_acct_t'(~a);
        acct_create_type_o <= rsc_acct_t'(~a);
        login_role_o       <= rsc_mgmt_t'(~r);
        grant_svc_o        <= rsc_svc_t'(~s);
        grant_keep_o       <= ~k;
        host_preboot_o     <= ~pre;
        @(negedge clk_sys_i);
    endtask : pulse
endmodule : rsc_host_model

// file: tb/tb_top.sv
/*
 * Self-checking bench for the role and session controller.
 * Assumes the host model drives all requests; answers checked mid-cycle.
 */
`timescale 1ns/1ps
module tb_top
    import rsc_pkg::*;
;
    typedef struct packed {
        rsc_acct_t a;
        rsc_mgmt_t r;
        logic      lok;
        rsc_svc_t  s;
        rsc_dp_t   d;
    } rsc_row_t;

    logic       clk_sys_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       ro_en     = 1'b0;
    logic       restart, error, purge, login, mlog, grant, keep;
    logic       dlog, create, delete, hrd, hwr, hpre;
    rsc_acct_t  lacct, ctype;
    rsc_mgmt_t  lrole, mgmt;
    rsc_svc_t   svc;
    rsc_dp_t    dp;
    logic       lack, lnak, gack, gnak, purged, aok, cen, ksel;
    logic [7:0] cnt;
    int         fail_count = 0;
    int         tests_run  = 0;

    rsc_row_t rows [11] = '{
        '{ACCT_INITIATOR, MGMT_INITIATOR, 1'b0, SVC_BOOT, DP_NONE},
        '{ACCT_INIT_OFFICER, MGMT_OFFICER, 1'b1, SVC_MIGRATE_KEY, DP_MIGRATE},
        '{ACCT_INIT_OFFICER, MGMT_OFFICER, 1'b1, SVC_UNLOCK_PREBOOT,
          DP_PREBOOT},
        '{ACCT_OFFICER, MGMT_OFFICER, 1'b1, SVC_BOOT, DP_SECURE},
        '{ACCT_INIT_OFFICER, MGMT_MANAGER, 1'b1, SVC_MIGRATE_KEY, DP_NONE},
        '{ACCT_OFFICER, MGMT_USER, 1'b1, SVC_UNLOCK_PREBOOT, DP_NONE},
        '{ACCT_MANAGER, MGMT_OFFICER, 1'b0, SVC_BOOT, DP_NONE},
        '{ACCT_MANAGER, MGMT_MANAGER, 1'b1, SVC_BOOT, DP_SECURE},
        '{ACCT_USER, MGMT_MANAGER, 1'b0, SVC_BOOT, DP_NONE},
        '{ACCT_USER, MGMT_USER, 1'b1, SVC_BOOT, DP_SECURE},
        '{ACCT_OFFICER, MGMT_INITIATOR, 1'b0, SVC_BOOT, DP_NONE}
    };

    always #5 clk_sys_i = ~clk_sys_i;

    rsc_host_model host (
        .clk_sys_i(clk_sys_i), .restart_o(restart), .error_o(error),
        .purge_o(purge), .login_o(login), .login_acct_o(lacct),
        .login_role_o(lrole), .mgmt_logout_o(mlog), .grant_o(grant),
        .grant_svc_o(svc), .grant_keep_o(keep), .dp_logout_o(dlog),
        .acct_create_o(create), .acct_create_type_o(ctype),
        .acct_delete_o(delete), .host_rd_o(hrd), .host_wr_o(hwr),
        .host_preboot_o(hpre)
    );

    rsc_role_session #(.ACCT_MAX(ACCT_MAX_DEF)) DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(restart),
        .error_i(error), .purge_i(purge), .login_i(login),
        .login_acct_i(lacct), .login_role_i(lrole), .mgmt_logout_i(mlog),
        .grant_i(grant), .grant_svc_i(svc), .grant_keep_i(keep),
        .dp_logout_i(dlog), .acct_create_i(create),
        .acct_create_type_i(ctype), .acct_delete_i(delete),
        .preboot_ro_en_i(ro_en), .host_rd_i(hrd), .host_wr_i(hwr),
        .host_preboot_i(hpre), .mgmt_role_o(mgmt), .dp_role_o(dp),
        .login_ack_o(lack), .login_nak_o(lnak), .grant_ack_o(gack),
        .grant_nak_o(gnak), .acct_count_o(cnt), .purged_o(purged),
        .access_ok_o(aok), .cipher_en_o(cen), .key_sel_o(ksel)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %0h want %0h", $time, seen,
                     exp);
        end
    endtask : chk

    task automatic do_login(input rsc_acct_t a, input rsc_mgmt_t r);
        host.pulse(3, a, r, SVC_BOOT, 1'b0, 1'b0);
    endtask : do_login

    task automatic do_grant(input rsc_svc_t s, input logic k);
        host.pulse(5, ACCT_USER, MGMT_USER, s, k, 1'b0);
    endtask : do_grant

    task automatic acc(input logic rd, input logic pre);
        host.pulse(rd ? 9 : 10, ACCT_USER, MGMT_USER, SVC_BOOT, 1'b0, pre);
    endtask : acc

    // 0 restart 1 error 2 purge 4/6 logouts 7 create 8 delete
    task automatic ev(input int unsigned sel, input rsc_acct_t a);
        host.pulse(sel, a, MGMT_USER, SVC_BOOT, 1'b0, 1'b0);
    endtask : ev

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // whole run is under 500 cycles; this bound only catches hangs
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(mgmt, MGMT_NONE);
        chk(dp, DP_NONE);
        chk(cnt, 8'h00);
        do_login(ACCT_OFFICER, MGMT_OFFICER);
        chk(lnak, 1'b1);
        do_login(ACCT_INITIATOR, MGMT_INITIATOR);
        chk(mgmt, MGMT_INITIATOR);
        do_grant(SVC_BOOT, 1'b1);
        chk(gnak, 1'b1);
        ev(7, ACCT_OFFICER);
        chk(cnt, 8'h00);
        ev(7, ACCT_INIT_OFFICER);
        chk(cnt, 8'h01);
        ev(7, ACCT_INIT_OFFICER);
        chk(cnt, 8'h01);
        ev(4, ACCT_USER);
        chk(mgmt, MGMT_NONE);
        foreach (rows[i]) begin
            do_login(rows[i].a, rows[i].r);
            chk(lack, rows[i].lok);
            do_grant(rows[i].s, 1'b1);
            chk(dp, rows[i].d);
            chk(gack, rows[i].d != DP_NONE);
            if (rows[i].d != DP_NONE) begin
                chk(mgmt, rows[i].r);
                acc(1'b1, 1'b0);
                chk(aok, rows[i].d != DP_PREBOOT);
                if (rows[i].d == DP_MIGRATE) chk(ksel, KEY_OLD);
                acc(1'b0, 1'b0);
                chk(cen, rows[i].d != DP_PREBOOT);
                if (rows[i].d == DP_MIGRATE) chk(ksel, KEY_NEW);
                acc(1'b0, 1'b1);
                chk(aok, rows[i].d == DP_PREBOOT);
            end
            ev(6, ACCT_USER);
            ev(4, ACCT_USER);
            chk(dp, DP_NONE);
            chk(mgmt, MGMT_NONE);
        end
        do_login(ACCT_OFFICER, MGMT_OFFICER);
        do_grant(SVC_BOOT, 1'b1);
        do_grant(SVC_MIGRATE_KEY, 1'b0);
        chk(gnak, 1'b1);
        chk(dp, DP_SECURE);
        do_login(ACCT_OFFICER, MGMT_MANAGER);
        chk(lnak, 1'b1);
        chk(mgmt, MGMT_OFFICER);
        ev(4, ACCT_USER);
        do_login(ACCT_MANAGER, MGMT_MANAGER);
        chk(lack, 1'b1);
        ev(1, ACCT_USER);
        chk(mgmt, MGMT_NONE);
        chk(dp, DP_NONE);
        do_login(ACCT_OFFICER, MGMT_OFFICER);
        do_grant(SVC_BOOT, 1'b0);
        chk(mgmt, MGMT_NONE);
        chk(dp, DP_SECURE);
        // refill the management slot so restart must empty both
        do_login(ACCT_USER, MGMT_USER);
        chk(mgmt, MGMT_USER);
        ev(0, ACCT_USER);
        chk(dp, DP_NONE);
        chk(mgmt, MGMT_NONE);
        // read-only preboot access with no datapath role held
        @(posedge clk_sys_i);
        ro_en <= 1'b1;
        acc(1'b1, 1'b1);
        chk(aok, 1'b1);
        acc(1'b0, 1'b1);
        chk(aok, 1'b0);
        acc(1'b1, 1'b0);
        chk(aok, 1'b0);
        do_login(ACCT_OFFICER, MGMT_OFFICER);
        repeat (130) ev(7, ACCT_USER);
        chk(cnt, 8'h80);
        ev(8, ACCT_USER);
        chk(cnt, 8'h7F);
        ev(7, ACCT_INIT_OFFICER);
        chk(cnt, 8'h7F);
        ev(7, ACCT_MANAGER);
        chk(cnt, 8'h80);
        ev(2, ACCT_USER);
        chk(purged, 1'b1);
        chk(cnt, 8'h00);
        do_login(ACCT_INITIATOR, MGMT_INITIATOR);
        chk(lnak, 1'b1);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(purged, 1'b0);
        do_login(ACCT_INITIATOR, MGMT_INITIATOR);
        chk(lack, 1'b1);
        wrap_up();
    end
endmodule : tb_top
